// ==== src/mcr_cell_block.sv ====
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/100ps
module mcr_cell_block #(
  parameter int          N_CELLS       = 16,
  parameter int          N_PINS        = 16,
  parameter bit          NEW_VARIANT   = 1'b1,
  parameter logic [15:0] POWER_UP_INIT = 16'h0000
) (
  input  wire logic                   clk,         // sample clock
  input  wire logic                   sys_rst,     // sync reset, high
  input  wire logic [mcr_pkg::AW-1:0] reg_addr,    // word address
  input  wire logic [mcr_pkg::DW-1:0] reg_wdata,   // write data
  input  wire logic                   reg_wr,      // write strobe
  input  wire logic                   reg_rd,      // read strobe
  output      logic [mcr_pkg::DW-1:0] reg_rdata,   // read data, next cycle
  input  wire logic                   global_clock_pin_a, // clock pin a
  input  wire logic                   global_clock_pin_b, // clock pin b
  input  wire logic                   global_clear_pin_low, // clear, low
  input  wire logic [N_PINS-1:0]      io_pin,      // pin inputs
  output      logic [N_CELLS-1:0]     cell_out     // cell outputs
);
  import mcr_pkg::*;

  localparam int W  = N_PINS + 2 * N_CELLS;
  localparam int NT = N_CELLS * TPC;
  localparam logic [N_CELLS-1:0] INIT_VAL =
    NEW_VARIANT ? POWER_UP_INIT[N_CELLS-1:0] : '0;

  // -----------------------------------------------------------------
  // configuration state
  // -----------------------------------------------------------------
  mcr_cell_cfg_type cfg      [N_CELLS];
  mcr_cell_cfg_type next_cfg [N_CELLS];
  mcr_gclk_cfg_type gcfg;
  mcr_gclk_cfg_type next_gcfg;
  logic [W-1:0]     tmask    [NT];
  logic [W-1:0]     cmask    [NT];

  logic [N_CELLS-1:0] st;
  logic [N_CELLS-1:0] next_st;
  logic [N_CELLS-1:0] next_out;
  logic [N_CELLS-1:0] exp_q;
  logic [N_CELLS-1:0] next_exp;
  logic [N_CELLS-1:0] aclk_q;
  logic [N_CELLS-1:0] next_aclk;
  logic [1:0]         gnet;
  logic [1:0]         gnet_q;
  logic [1:0]         gedge;
  logic [DW-1:0]      next_rdata;

  logic [W-1:0]       arr;
  logic [NT-1:0]      pt;
  logic [N_CELLS-1:0] lsum;
  logic [N_CELLS-1:0] sum;
  logic [N_CELLS-1:0] dval;
  logic [N_CELLS-1:0] hit;
  logic [N_CELLS-1:0] clr_any;
  logic [N_CELLS-1:0] pre_any;
  logic [N_CELLS-1:0] ffn;

  // -----------------------------------------------------------------
  // register writes and readback
  // -----------------------------------------------------------------
  // config words decode from the low bits of the write data
  always_comb begin
    next_gcfg = gcfg;
    for (int i = 0; i < N_CELLS; i++) begin
      next_cfg[i] = cfg[i];
      if (reg_wr && reg_addr == CFG_BASE + AW'(i)) begin
        next_cfg[i] = mcr_cell_cfg_type'(reg_wdata[CFG_W-1:0]);
      end
    end
    if (reg_wr && reg_addr == GCFG_ADDR) begin
      next_gcfg = mcr_gclk_cfg_type'(reg_wdata[3:0]);
    end
  end

  // unmapped addresses read zero; rdata is zero outside read replies
  always_comb begin
    next_rdata = '0;
    if (reg_rd) begin
      if (int'(reg_addr) < 2 * NT) begin
        if (reg_addr[0]) begin
          next_rdata[W-1:0] = cmask[int'(reg_addr) >> 1];
        end else begin
          next_rdata[W-1:0] = tmask[int'(reg_addr) >> 1];
        end
      end
      for (int i = 0; i < N_CELLS; i++) begin
        if (reg_addr == CFG_BASE + AW'(i)) begin
          next_rdata[CFG_W-1:0] = cfg[i];
        end
      end
      if (reg_addr == GCFG_ADDR) begin
        next_rdata[3:0] = gcfg;
      end
      if (reg_addr == STAT_ADDR) begin
        next_rdata[N_CELLS-1:0] = cell_out;
      end
      if (reg_addr == EXP_ADDR) begin
        next_rdata[N_CELLS-1:0] = exp_q;
      end
    end
  end

  // term masks are a plain memory, written in place
  always_ff @(posedge clk) begin
    for (int k = 0; k < NT; k++) begin
      if (sys_rst) begin
        tmask[k] <= '0;
        cmask[k] <= '0;
      end else if (reg_wr && int'(reg_addr) == 2 * k) begin
        tmask[k] <= reg_wdata[W-1:0];
      end else if (reg_wr && int'(reg_addr) == 2 * k + 1) begin
        cmask[k] <= reg_wdata[W-1:0];
      end
    end
  end

  // -----------------------------------------------------------------
  // logic array and global nets
  // -----------------------------------------------------------------
  // expanders return inverted into the array, visible to all cells
  assign arr = {exp_q, cell_out, io_pin};

  // a term with no literal selected is true
  always_comb begin
    for (int k = 0; k < NT; k++) begin
      pt[k] = &((~tmask[k] | arr) & (~cmask[k] | ~arr));
    end
  end

  // each net picks either pin, true or inverted
  always_comb begin
    gnet[0] = (gcfg.sel0 ? global_clock_pin_b : global_clock_pin_a)
              ^ gcfg.inv0;
    gnet[1] = (gcfg.sel1 ? global_clock_pin_b : global_clock_pin_a)
              ^ gcfg.inv1;
    gedge   = gnet & ~gnet_q;
  end

  // -----------------------------------------------------------------
  // macrocell next state
  // -----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < N_CELLS; i++) begin
      lsum[i] = |(pt[i*TPC +: NLOC] & cfg[i].sum_sel);
    end
    for (int i = 0; i < N_CELLS; i++) begin
      // lender keeps its own sum; borrowing is additive only
      sum[i] = lsum[i] | (cfg[i].par_en &&
               int'(cfg[i].par_src) < N_CELLS &&
               lsum[int'(cfg[i].par_src) % N_CELLS]);
      dval[i] = sum[i];
      if (cfg[i].fast_en && int'(cfg[i].fast_pin) < N_PINS) begin
        dval[i] = io_pin[int'(cfg[i].fast_pin) % N_PINS];
      end
      case (cfg[i].clk_mode)
        MCR_GCLK_EN: hit[i] = gedge[cfg[i].gnet]
                              & pt[i*TPC+T_CLK];
        MCR_ACLK:    hit[i] = pt[i*TPC+T_CLK]
                              & ~aclk_q[i];
        default:     hit[i] = gedge[cfg[i].gnet];
      endcase
      case (cfg[i].ff)
        MCR_T:   ffn[i] = st[i] ^ dval[i];
        MCR_JK:  ffn[i] = (dval[i] & ~st[i])
                          | (~pt[i*TPC+T_K] & st[i]);
        MCR_SR:  ffn[i] = dval[i]
                          | (~pt[i*TPC+T_K] & st[i]);
        default: ffn[i] = dval[i];
      endcase
      clr_any[i] = (cfg[i].clr_en & pt[i*TPC+T_CLR])
                   | (cfg[i].gclr_en & ~global_clear_pin_low);
      pre_any[i] = cfg[i].pre_en & pt[i*TPC+T_PRE];
      // clear wins over preset, both win over capture
      if (clr_any[i]) begin
        next_st[i] = 1'b0;
      end else if (pre_any[i]) begin
        next_st[i] = 1'b1;
      end else if (hit[i]) begin
        next_st[i] = ffn[i];
      end else begin
        next_st[i] = st[i];
      end
      next_out[i]  = cfg[i].comb ? sum[i] : next_st[i];
      next_exp[i]  = ~pt[i*TPC+T_EXP];
      next_aclk[i] = pt[i*TPC+T_CLK];
    end
  end

  // outputs register once per sample so feedback never loops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st        <= INIT_VAL;
      cell_out  <= INIT_VAL;
      exp_q     <= '0;
      aclk_q    <= '0;
      gnet_q    <= 2'h0;
      gcfg      <= mcr_gclk_cfg_type'(GCFG_RST);
      reg_rdata <= '0;
      for (int i = 0; i < N_CELLS; i++) begin
        cfg[i] <= mcr_cell_cfg_type'(CFG_RST);
      end
    end else begin
      st        <= next_st;
      cell_out  <= next_out;
      exp_q     <= next_exp;
      aclk_q    <= next_aclk;
      gnet_q    <= gnet;
      gcfg      <= next_gcfg;
      reg_rdata <= next_rdata;
      for (int i = 0; i < N_CELLS; i++) begin
        cfg[i] <= next_cfg[i];
      end
    end
  end

  // -----------------------------------------------------------------
  // checks on cells 0 and 6 to 9; the bench rotates the flip-flop types of cells 6 to 8
  // -----------------------------------------------------------------
  property p_d_capture;
    @(posedge clk) disable iff (sys_rst)
    (cfg[0].ff == MCR_D && hit[0] && !clr_any[0] && !pre_any[0])
    |=> st[0] == $past(dval[0]);
  endproperty
  a_d_capture: assert property (p_d_capture)
    else $error("d capture wrong");

  property p_t_toggle;
    @(posedge clk) disable iff (sys_rst)
    (cfg[6].ff == MCR_T && hit[6] && dval[6] && !clr_any[6]
     && !pre_any[6]) |=> st[6] != $past(st[6]);
  endproperty
  a_t_toggle: assert property (p_t_toggle)
    else $error("t did not toggle");

  property p_comb;
    @(posedge clk) disable iff (sys_rst)
    cfg[0].comb |=> cell_out[0] == $past(sum[0]);
  endproperty
  a_comb: assert property (p_comb)
    else $error("bypass output wrong");

  property p_en_hold;
    @(posedge clk) disable iff (sys_rst)
    (cfg[7].clk_mode == MCR_GCLK_EN && !pt[7*TPC+T_CLK] && !clr_any[7]
     && !pre_any[7]) |=> $stable(st[7]);
  endproperty
  a_en_hold: assert property (p_en_hold)
    else $error("disabled cell changed");

  property p_aclk;
    @(posedge clk) disable iff (sys_rst)
    (cfg[8].clk_mode == MCR_ACLK && cfg[8].ff == MCR_D && pt[8*TPC+T_CLK]
     && !aclk_q[8] && !clr_any[8] && !pre_any[8])
    |=> st[8] == $past(dval[8]);
  endproperty
  a_aclk: assert property (p_aclk)
    else $error("array clock capture missed");

  property p_gnet;
    @(posedge clk) disable iff (sys_rst)
    ($rose(global_clock_pin_a) && $stable(gcfg) && !gcfg.sel0
     && !gcfg.inv0) |-> gedge[0];
  endproperty
  a_gnet: assert property (p_gnet)
    else $error("global net edge missed");

  property p_gclr;
    @(posedge clk) disable iff (sys_rst)
    (cfg[9].gclr_en && !global_clear_pin_low) |=> !st[9];
  endproperty
  a_gclr: assert property (p_gclr)
    else $error("global clear ignored");

  property p_pre;
    @(posedge clk) disable iff (sys_rst)
    (pre_any[9] && !clr_any[9]) |=> st[9];
  endproperty
  a_pre: assert property (p_pre)
    else $error("preset ignored");

  property p_clr_wins;
    @(posedge clk) disable iff (sys_rst)
    (clr_any[9] && pre_any[9]) |=> !st[9] ##1 1'b1;
  endproperty
  a_clr_wins: assert property (p_clr_wins)
    else $error("clear lost to preset");

  property p_powerup;
    @(posedge clk)
    sys_rst |=> st[0] == INIT_VAL[0];
  endproperty
  a_powerup: assert property (p_powerup)
    else $error("power-up value wrong");

  c_en_capture: cover property (@(posedge clk) disable iff (sys_rst)
    cfg[7].clk_mode == MCR_GCLK_EN && hit[7]);
  c_aclk: cover property (@(posedge clk) disable iff (sys_rst)
    cfg[8].clk_mode == MCR_ACLK && hit[8]);
  c_comb: cover property (@(posedge clk) disable iff (sys_rst)
    cfg[0].comb && $changed(cell_out[0]));
  c_gclr: cover property (@(posedge clk) disable iff (sys_rst)
    cfg[9].gclr_en && !global_clear_pin_low && st[9]);

endmodule

// ==== src/mcr_pkg.sv ====
// Functional notes
// - each cell's storage acts as D, T, JK or SR, chosen per cell
// - combinational cells pass the logic sum around the flip-flop
// - three clock modes: global, global with enable, array clock
// - gated global mode captures only when the enable term is high
// - array clock mode clocks on a rising product term edge
// - two global nets, each true or inverted copy of either clock pin
// - preset and clear come from product terms, both active high
// - clear may also come from the active-low global clear pin
// - newer variant: power-up value chosen per cell at build time
// - older variant: every cell powers up low
// - fast input path from a pin straight to the cell's data input
// - each cell sums up to five local product terms
// - sixteen shareable expanders, inverted and fed back into the array
// - any expander may feed any number of cells of the block
// - parallel expanders lend one cell's local sum to another cell
package mcr_pkg;

  // -----------------------------------------------------------------
  // bus and array geometry
  // -----------------------------------------------------------------
  localparam int AW     = 10;  // register word address width
  localparam int DW     = 64;  // register data width
  localparam int NLOC   = 5;   // local terms per cell
  localparam int TPC    = 6;   // terms per cell, expander included

  // roles of the cell's terms beside the sum
  localparam int T_CLK  = 1;   // clock enable or array clock
  localparam int T_CLR  = 2;   // product-term clear
  localparam int T_PRE  = 3;   // product-term preset
  localparam int T_K    = 4;   // second input for jk and sr types
  localparam int T_EXP  = 5;   // shareable expander term

  // -----------------------------------------------------------------
  // register map, word addresses
  // -----------------------------------------------------------------
  localparam logic [AW-1:0] TERM_BASE = 10'h000;
  localparam logic [AW-1:0] CFG_BASE  = 10'h100;
  localparam logic [AW-1:0] GCFG_ADDR = 10'h200;
  localparam logic [AW-1:0] STAT_ADDR = 10'h201;
  localparam logic [AW-1:0] EXP_ADDR  = 10'h202;

  typedef enum logic [1:0] {
    MCR_D  = 2'h0,
    MCR_T  = 2'h1,
    MCR_JK = 2'h2,
    MCR_SR = 2'h3
  } mcr_ff_type;

  typedef enum logic [1:0] {
    MCR_GCLK    = 2'h0,
    MCR_GCLK_EN = 2'h1,
    MCR_ACLK    = 2'h2
  } mcr_clk_type;

  // per-cell configuration word, bits 1:0 are ff
  typedef struct packed {
    logic [3:0]  par_src;   // cell whose local sum is borrowed
    logic [3:0]  fast_pin;  // pin for the fast input path
    logic [4:0]  sum_sel;   // local terms that enter the sum
    logic        par_en;
    logic        fast_en;
    logic        gclr_en;
    logic        clr_en;
    logic        pre_en;
    logic        comb;
    logic        gnet;      // global net used by this cell
    mcr_clk_type clk_mode;
    mcr_ff_type  ff;
  } mcr_cell_cfg_type;

  localparam int CFG_W = 24;
  localparam logic [CFG_W-1:0] CFG_RST = 24'h000000;

  // global net selection: sel 0 is pin a, 1 is pin b
  typedef struct packed {
    logic inv1;
    logic sel1;
    logic inv0;
    logic sel0;
  } mcr_gclk_cfg_type;

  localparam logic [3:0] GCFG_RST = 4'h0;

endpackage

// ==== test/tb.sv ====
`timescale 1ns/100ps
module tb;
  import mcr_pkg::*;
  // ---------------------------------------------------------------
  // stimulus, model state and counters
  // ---------------------------------------------------------------
  localparam logic [15:0] INIT = 16'ha5c3;
  logic             clk       = 1'b0;
  logic             sys_rst   = 1'b1;
  logic [AW-1:0]    reg_addr  = '0;
  logic [DW-1:0]    reg_wdata = '0;
  logic             reg_wr    = 1'b0;
  logic             reg_rd    = 1'b0;
  logic             pin_a     = 1'b0;
  logic             pin_b     = 1'b0;
  logic             clr_low   = 1'b1;
  logic [15:0]      io_pin    = '0;
  logic [DW-1:0]    reg_rdata;
  logic [15:0]      cell_out;
  logic [47:0]      tm [0:191];
  mcr_cell_cfg_type m_cfg [0:15];
  logic [15:0]      m_out, m_exp, m_t1, io, io2;
  logic [3:0]       m_g;
  logic [1:0]       m_net, tt;
  logic [31:0]      r;
  int               fails, compares, cycles, seed;

  mcr_cell_block #(.NEW_VARIANT(1'b1), .POWER_UP_INIT(INIT)) dut (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .global_clock_pin_a(pin_a),
    .global_clock_pin_b(pin_b), .global_clear_pin_low(clr_low),
    .io_pin(io_pin), .cell_out(cell_out));

  // free-running clock, 8 ns period
  initial begin
    forever #4 clk = ~clk;
  end

  // hang guard: far above the few thousand cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      finish_test();
    end
  end

  // ---------------------------------------------------------------
  // compare, report and bus tasks
  // ---------------------------------------------------------------
  task automatic chk_out(logic [15:0] got, logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t out got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_rd(logic [DW-1:0] got, logic [DW-1:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t rd got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // one idle cycle after each strobe keeps back-to-back calls clean
  task automatic wr(logic [AW-1:0] a, logic [DW-1:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(logic [AW-1:0] a, logic [DW-1:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk_rd(reg_rdata, e);
    @(posedge clk);
  endtask

  task automatic setterm(int c, int t, logic [47:0] tru, logic [47:0] inv);
    tm[2*(c*TPC+t)] = tru;
    tm[2*(c*TPC+t)+1] = inv;
    wr(TERM_BASE + 10'(2*(c*TPC+t)), {16'h0, tru});
    wr(TERM_BASE + 10'(2*(c*TPC+t)+1), {16'h0, inv});
  endtask

  task automatic setcfg(int c, logic [23:0] v);
    m_cfg[c] = mcr_cell_cfg_type'(v);
    wr(CFG_BASE + 10'(c), {40'h0, v});
  endtask

  // ---------------------------------------------------------------
  // behavioural model of the cell array
  // ---------------------------------------------------------------
  function automatic logic term(int k, logic [47:0] v);
    return ((v & tm[2*k]) == tm[2*k]) && ((~v & tm[2*k+1]) == tm[2*k+1]);
  endfunction

  function automatic logic lsum(int c, logic [47:0] v);
    logic s;
    s = 1'b0;
    for (int t = 0; t < NLOC; t++)
      s |= m_cfg[c].sum_sel[t] & term(c*TPC+t, v);
    return s;
  endfunction

  // borrowed sum from the par_src cell, any cell of the block, adds to this cell's own
  function automatic logic csum(int c, logic [47:0] v);
    return lsum(c, v) | (m_cfg[c].par_en & lsum(m_cfg[c].par_src, v));
  endfunction

  // drive, let the array settle, then advance the model and compare
  task automatic step(logic [15:0] i, logic a, logic b, logic gn);
    logic [47:0]      v;
    logic [15:0]      nx;
    logic [1:0]       net;
    logic             q, d, k, t1, ev;
    mcr_cell_cfg_type cf;
    io_pin <= i;
    pin_a <= a;
    pin_b <= b;
    clr_low <= gn;
    repeat (6) @(posedge clk);
    net = {(m_g[2] ? b : a) ^ m_g[3], (m_g[0] ? b : a) ^ m_g[1]};
    v = {m_exp, m_out, i};
    nx = m_out;
    for (int c = 0; c < 16; c++) begin
      cf = m_cfg[c];
      t1 = term(c*TPC+T_CLK, v);
      d = cf.fast_en ? i[cf.fast_pin] : csum(c, v);
      k = term(c*TPC+T_K, v);
      q = m_out[c];
      ev = (cf.clk_mode == MCR_ACLK) ? (t1 & !m_t1[c])
         : (net[cf.gnet] & !m_net[cf.gnet] & (t1 | cf.clk_mode != MCR_GCLK_EN));
      if (ev) begin
        case (cf.ff)
          MCR_D:   q = d;
          MCR_T:   q = q ^ d;
          MCR_JK:  q = (d & !q) | (!k & q);
          default: q = d | (!k & q);
        endcase
      end
      if (cf.pre_en & term(c*TPC+T_PRE, v))
        q = 1'b1;
      if ((cf.clr_en & term(c*TPC+T_CLR, v)) | (cf.gclr_en & !gn))
        q = 1'b0;
      nx[c] = q;
      m_t1[c] = t1;
    end
    m_net = net;
    m_out = nx;
    repeat (3) begin
      v = {m_exp, m_out, i};
      for (int c = 0; c < 16; c++) begin
        m_exp[c] = !term(c*TPC+T_EXP, v);
        if (m_cfg[c].comb)
          m_out[c] = csum(c, v);
      end
    end
    #1;
    chk_out(cell_out, m_out);
    rd(EXP_ADDR, {48'h0, m_exp});
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 32'h76b3;
    foreach (tm[i]) tm[i] = '0;
    foreach (m_cfg[i]) m_cfg[i] = '0;
    m_out = INIT;
    m_exp = '0;
    m_t1 = '1;
    m_g = '0;
    m_net = '0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk_out(cell_out, INIT);
    rd(CFG_BASE, '0);
    rd(GCFG_ADDR, '0);
    wr(10'h3ff, '1);
    rd(10'h3ff, '0);
    for (int g = 0; g < 2; g++) begin
      m_g = g ? 4'hc : 4'h3;
      wr(GCFG_ADDR, {60'h0, m_g});
      // the net edge from the new selection lands before this step's
      // inputs change, so keep the clear pin where it already stands
      step(io_pin, 1'b0, 1'b0, clr_low);
      if (g == 0) begin
        for (int t = 0; t < 4; t++)
          setterm(0, t, 48'h1 << t, '0);
        setterm(0, 4, '0, 48'h80);
        setterm(2, T_EXP, 48'h100, 48'h200);
        setterm(3, 0, 48'h1 << 34, '0);
        setterm(4, 0, 48'h1 << 34, '0);
        setterm(5, 0, 48'h400, '0);
        for (int c = 6; c < 10; c++)
          setterm(c, 0, 48'h800, '0);
        setterm(6, T_K, 48'h1000, '0);
        setterm(7, T_CLK, 48'h2000, '0);
        setterm(8, T_CLK, 48'h4000, '0);
        setterm(9, T_PRE, 48'h10, '0);
        setterm(9, T_CLR, 48'h20, '0);
        setterm(10, 0, '0, 48'h8000);
        setcfg(0, {13'h01f, 7'b0000010, 4'h0});
        setcfg(3, {13'h001, 7'b0000010, 4'h0});
        setcfg(4, {13'h001, 7'b0000010, 4'h0});
        setcfg(5, {13'h001, 7'b1000010, 4'h0});
        setcfg(9, {13'h001, 7'b0011101, 4'hc});
        setcfg(10, {13'h1e01, 7'b0100000, 4'h0});
        rd(CFG_BASE + 10'd10, {40'h0, m_cfg[10]});
      end
      for (int ty = 0; ty < 4; ty++) begin
        tt = 2'(ty);
        setcfg(6, {13'h001, 6'h0, tt[0], 2'h0, tt});
        setcfg(7, {13'h001, 7'h0, 2'h1, tt});
        setcfg(8, {13'h001, 7'h0, 2'h2, tt});
        for (int n = 0; n < 6; n++) begin
          r = $random(seed);
          io = r[15:0] & 16'hbfff;
          io2 = io | 16'h4000;
          step(io, 1'b0, 1'b0, |r[31:30]);
          step(io2, 1'b0, 1'b0, |r[31:30]);
          step(io2, 1'b1, 1'b0, |r[31:30]);
          step(io2, 1'b0, 1'b0, |r[31:30]);
          step(io2, 1'b0, 1'b1, |r[31:30]);
          step(io2, 1'b0, 1'b0, |r[31:30]);
        end
      end
    end
    rd(GCFG_ADDR, {60'h0, 4'hc});
    rd(STAT_ADDR, {48'h0, m_out});
    finish_test();
  end
endmodule
